/* pkg/lp_pkg.sv */
// Purpose: shared types and constants of the low-power state controller
// Assumes: one bus clock of 40 MHz; two cores
// Notes: vid and ratio widths are plain defaults
package lp_pkg;

	// ==========================================
	// sizes
	localparam int NUM_CORES = 2;
	localparam int VID_W = 6;
	localparam int RATIO_W = 5;
	localparam int CNT_W = 5;

	// ==========================================
	// timing, in bus clocks
	localparam logic [CNT_W-1:0] GRANT_DELAY_CLKS = 5'h14;
	localparam logic [CNT_W-1:0] RATIO_SETTLE_CLKS = 5'h04;
	localparam logic [CNT_W-1:0] VID_STEP_CLKS = 5'h02;

	// ==========================================
	// reset values
	localparam logic [VID_W-1:0] VID_RESET_CODE = 6'h00;
	localparam logic [RATIO_W-1:0] RATIO_RESET = 5'h06;

	// ==========================================
	// states
	typedef enum logic [3:0] {
		ST_NORMAL,
		ST_RATIO_DOWN,
		ST_VID_DOWN,
		ST_HALT,
		ST_HALT_SNOOP,
		ST_GRANT_ACK,
		ST_GRANT_WAIT,
		ST_GRANT,
		ST_GRANT_SNOOP,
		ST_VID_UP,
		ST_RATIO_UP
	} lp_state_type;

	// ==========================================
	// carriers
	typedef struct packed {
		logic bus_reset_n;
		logic stop_clock_request_n;
		logic system_mgmt_interrupt_n;
		logic init_request_n;
		logic [1:0] local_interrupt_pins;
	} pins_type;

	typedef struct packed {
		logic smi;
		logic init;
		logic lint;
	} events_type;

endpackage

/* rtl/low_power_state_controller.sv */
// Purpose: package low-power state controller: halt, stop-grant, extended states
// Assumes: core, bus and config inputs are on clk; pins go through pin_sync
// Notes: ratio and vid only move the core clock; the bus clock is never touched
//
// How it works
// - package halt only when every core has halted or executed monitor wait
// - a halted core stops alone; other cores keep running
// - smi, init or local interrupt wakes halted cores back to normal
// - bus reset in halt starts initialisation at once
// - stop-clock accepted in halt; its release returns to halt
// - snoops are serviced in halt, extended halt and stop-grant
// - all cores halted enters extended halt when enabled, else plain halt
// - extended entry lowers core ratio first, then steps vid down
// - extended exit restores vid first at low speed, then the ratio
// - only the core ratio changes; the bus clock stays as it is
// - stop-clock issues a grant acknowledge; stop-grant 20 clocks after response
// - bus reset in stop-grant initialises but stays in stop-grant
// - releasing stop-clock takes stop-grant back to normal
// - a snoop in stop-grant moves to the grant snoop state
// - events in stop-grant are held, one each, served back in normal or halt
// - stop-clock with extended grant enabled enters extended stop-grant
// - smi handler exit resumes in normal or back in halt
// - after a serviced snoop return to the low-power state left
`timescale 1ns/10ps
module low_power_state_controller (
	input wire logic clk,
	input wire logic nrst,
	input wire lp_pkg::pins_type pins,
	input wire logic [lp_pkg::NUM_CORES-1:0] core_halt_exec,
	input wire logic smi_exit_valid,
	input wire logic smi_exit_to_halt,
	input wire logic snoop_req,
	input wire logic snoop_done,
	input wire logic bus_resp_done,
	input wire logic ext_halt_en,
	input wire logic ext_grant_en,
	input wire logic [lp_pkg::RATIO_W-1:0] normal_ratio,
	input wire logic [lp_pkg::RATIO_W-1:0] low_ratio,
	input wire logic [lp_pkg::VID_W-1:0] normal_vid,
	input wire logic [lp_pkg::VID_W-1:0] low_vid,
	output lp_pkg::lp_state_type lp_state,
	output logic [lp_pkg::NUM_CORES-1:0] core_run,
	output logic stop_grant_cycle_req,
	output logic snoop_serve,
	output logic init_start,
	output lp_pkg::events_type event_service,
	output logic [lp_pkg::RATIO_W-1:0] core_ratio,
	output logic [lp_pkg::VID_W-1:0] voltage_id_code
);
	localparam lp_pkg::pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0};

	lp_pkg::lp_state_type state_reg, state_next, dest_reg;
	lp_pkg::pins_type pin_s, pin_prev_reg;
	lp_pkg::events_type ev, pend_reg, deliver, service_reg;
	logic [lp_pkg::NUM_CORES-1:0] halted_reg, halted_next, core_run_reg;
	logic [lp_pkg::CNT_W-1:0] cnt_reg;
	logic [lp_pkg::RATIO_W-1:0] ratio_reg;
	logic [lp_pkg::VID_W-1:0] vid_target;
	logic ext_reg, ret_halt_reg, halt_ext_reg, ratio_low_reg, vid_low_reg;
	logic ack_reg, snoop_reg, init_reg, stopclk, reset_fall, in_grant, at_target, wake;

	function automatic logic grant_family(input lp_pkg::lp_state_type s);
		return s == lp_pkg::ST_GRANT_ACK || s == lp_pkg::ST_GRANT_WAIT ||
			s == lp_pkg::ST_GRANT || s == lp_pkg::ST_GRANT_SNOOP;
	endfunction

	function automatic logic runs(input lp_pkg::lp_state_type s);
		return s == lp_pkg::ST_NORMAL || s == lp_pkg::ST_VID_UP || s == lp_pkg::ST_RATIO_UP;
	endfunction

	// ==========================================
	// pin capture and event edges
	pin_sync #(.W($bits(lp_pkg::pins_type)), .RESET_VAL(PINS_IDLE)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.d(pins),
		.q(pin_s)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_prev_reg <= PINS_IDLE;
		end else begin
			pin_prev_reg <= pin_s;
		end
	end

	assign stopclk = !pin_s.stop_clock_request_n;
	assign reset_fall = pin_prev_reg.bus_reset_n && !pin_s.bus_reset_n;
	assign ev.smi = pin_prev_reg.system_mgmt_interrupt_n && !pin_s.system_mgmt_interrupt_n;
	assign ev.init = pin_prev_reg.init_request_n && !pin_s.init_request_n;
	assign ev.lint = |(pin_s.local_interrupt_pins & ~pin_prev_reg.local_interrupt_pins);

	// events outside normal and halt are held, so a snoop or a transition loses none;
	// they are served once back in one of those two states
	assign in_grant = !(state_reg == lp_pkg::ST_NORMAL || state_reg == lp_pkg::ST_HALT);
	assign deliver = (state_reg == lp_pkg::ST_NORMAL || state_reg == lp_pkg::ST_HALT) ?
		(ev | pend_reg) : '0;
	assign wake = |deliver;

	// ==========================================
	// next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			lp_pkg::ST_NORMAL: begin
				if (stopclk) begin
					state_next = lp_pkg::ST_GRANT_ACK;
				end else if (&halted_next && !wake) begin
					state_next = ext_halt_en ? lp_pkg::ST_RATIO_DOWN : lp_pkg::ST_HALT;
				end
			end
			lp_pkg::ST_RATIO_DOWN: begin
				if (cnt_reg == lp_pkg::RATIO_SETTLE_CLKS - 1'b1) begin
					state_next = lp_pkg::ST_VID_DOWN;
				end
			end
			lp_pkg::ST_VID_DOWN: begin
				if (at_target) begin
					state_next = dest_reg;
				end
			end
			lp_pkg::ST_HALT: begin
				if (wake) begin
					state_next = ext_reg ? lp_pkg::ST_VID_UP : lp_pkg::ST_NORMAL;
				end else if (stopclk) begin
					state_next = lp_pkg::ST_GRANT_ACK;
				end else if (snoop_req) begin
					state_next = lp_pkg::ST_HALT_SNOOP;
				end
			end
			lp_pkg::ST_HALT_SNOOP: begin
				if (snoop_done) begin
					state_next = lp_pkg::ST_HALT;
				end
			end
			lp_pkg::ST_GRANT_ACK: begin
				if (bus_resp_done) begin
					state_next = lp_pkg::ST_GRANT_WAIT;
				end
			end
			lp_pkg::ST_GRANT_WAIT: begin
				if (cnt_reg == lp_pkg::GRANT_DELAY_CLKS - 1'b1) begin
					state_next = (ext_grant_en && !ext_reg) ? lp_pkg::ST_RATIO_DOWN :
						lp_pkg::ST_GRANT;
				end
			end
			lp_pkg::ST_GRANT: begin
				if (!stopclk) begin
					if (ext_reg && !(ret_halt_reg && halt_ext_reg)) begin
						state_next = lp_pkg::ST_VID_UP;
					end else begin
						state_next = ret_halt_reg ? lp_pkg::ST_HALT : lp_pkg::ST_NORMAL;
					end
				end else if (snoop_req) begin
					state_next = lp_pkg::ST_GRANT_SNOOP;
				end
			end
			lp_pkg::ST_GRANT_SNOOP: begin
				if (snoop_done) begin
					state_next = lp_pkg::ST_GRANT;
				end
			end
			lp_pkg::ST_VID_UP: begin
				if (at_target) begin
					state_next = lp_pkg::ST_RATIO_UP;
				end
			end
			lp_pkg::ST_RATIO_UP: begin
				state_next = dest_reg;
			end
		endcase
		// bus reset re-initialises; a stop-grant stays where it is
		if (reset_fall && !grant_family(state_reg)) begin
			state_next = lp_pkg::ST_NORMAL;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= lp_pkg::ST_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// where a transition sequence ends, and how it got there
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dest_reg <= lp_pkg::ST_NORMAL;
			ext_reg <= 1'b0;
			ret_halt_reg <= 1'b0;
			halt_ext_reg <= 1'b0;
		end else if (reset_fall && !grant_family(state_reg)) begin
			dest_reg <= lp_pkg::ST_NORMAL;
			ext_reg <= 1'b0;
			ret_halt_reg <= 1'b0;
		end else if (state_next != state_reg) begin
			unique case (state_next)
				lp_pkg::ST_RATIO_DOWN: begin
					ext_reg <= 1'b1;
					dest_reg <= (state_reg == lp_pkg::ST_NORMAL) ? lp_pkg::ST_HALT :
						lp_pkg::ST_GRANT;
				end
				lp_pkg::ST_GRANT_ACK: begin
					ret_halt_reg <= (state_reg == lp_pkg::ST_HALT);
					halt_ext_reg <= ext_reg && state_reg == lp_pkg::ST_HALT;
				end
				lp_pkg::ST_VID_UP: begin
					dest_reg <= (state_reg == lp_pkg::ST_GRANT && ret_halt_reg) ?
						lp_pkg::ST_HALT : lp_pkg::ST_NORMAL;
				end
				lp_pkg::ST_HALT, lp_pkg::ST_NORMAL: begin
					if (state_reg == lp_pkg::ST_RATIO_UP) begin
						ext_reg <= 1'b0;
					end
					if (state_reg == lp_pkg::ST_GRANT) begin
						ret_halt_reg <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (state_next != state_reg) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// ==========================================
	// per-core halt tracking; a new halt beats a same-cycle wake
	always_comb begin
		halted_next = halted_reg;
		if (wake || reset_fall) begin
			halted_next = '0;
		end
		if (state_reg == lp_pkg::ST_NORMAL && smi_exit_valid && smi_exit_to_halt) begin
			halted_next = '1;
		end
		halted_next = halted_next | core_halt_exec;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			halted_reg <= '0;
			core_run_reg <= '0;
		end else begin
			halted_reg <= halted_next;
			core_run_reg <= runs(state_next) ? ~halted_next : '0;
		end
	end

	// ==========================================
	// held events: one of each, a new edge wins over the clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_reg <= '0;
			service_reg <= '0;
		end else begin
			pend_reg <= (pend_reg & ~deliver) | (in_grant ? ev : '0);
			service_reg <= deliver;
		end
	end

	// ==========================================
	// operating point: ratio leads on the way down, vid leads on the way up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ratio_low_reg <= 1'b0;
			vid_low_reg <= 1'b0;
		end else if (reset_fall && !grant_family(state_reg)) begin
			ratio_low_reg <= 1'b0;
			vid_low_reg <= 1'b0;
		end else begin
			if (state_next == lp_pkg::ST_RATIO_DOWN) begin
				ratio_low_reg <= 1'b1;
			end else if (state_next == lp_pkg::ST_RATIO_UP) begin
				ratio_low_reg <= 1'b0;
			end
			if (state_next == lp_pkg::ST_VID_DOWN) begin
				vid_low_reg <= 1'b1;
			end else if (state_next == lp_pkg::ST_VID_UP) begin
				vid_low_reg <= 1'b0;
			end
		end
	end

	// only the core multiplier moves; no bus clock is produced here
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ratio_reg <= lp_pkg::RATIO_RESET;
		end else begin
			ratio_reg <= ratio_low_reg ? low_ratio : normal_ratio;
		end
	end

	assign vid_target = vid_low_reg ? low_vid : normal_vid;

	vid_stepper u_vid (
		.clk(clk),
		.nrst(nrst),
		.target(vid_target),
		.vid(voltage_id_code),
		.at_target(at_target)
	);

	// ==========================================
	// bus-side strobes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_reg <= 1'b0;
			snoop_reg <= 1'b0;
			init_reg <= 1'b0;
		end else begin
			ack_reg <= (state_next == lp_pkg::ST_GRANT_ACK);
			snoop_reg <= (state_next == lp_pkg::ST_HALT_SNOOP ||
				state_next == lp_pkg::ST_GRANT_SNOOP);
			init_reg <= reset_fall;
		end
	end

	assign lp_state = state_reg;
	assign core_run = core_run_reg;
	assign stop_grant_cycle_req = ack_reg;
	assign snoop_serve = snoop_reg;
	assign init_start = init_reg;
	assign event_service = service_reg;
	assign core_ratio = ratio_reg;

	// ==========================================
	// checks
	property p_halt_entry;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_NORMAL && state_next == lp_pkg::ST_HALT) |-> &halted_next;
	endproperty
	a_halt_entry: assert property (p_halt_entry) else $error("halt without all cores halted");

	property p_core_run;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_NORMAL && $past(nrst)) |-> core_run_reg == ~halted_reg;
	endproperty
	a_core_run: assert property (p_core_run) else $error("running cores do not match halts");

	property p_wake;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_HALT && wake) |=> state_reg != lp_pkg::ST_HALT;
	endproperty
	a_wake: assert property (p_wake) else $error("break event did not leave halt");

	property p_grant_delay;
		@(posedge clk) disable iff (!nrst)
		$rose(state_reg == lp_pkg::ST_GRANT_WAIT) |->
			(state_reg == lp_pkg::ST_GRANT_WAIT) [*8] ##12 state_reg == lp_pkg::ST_GRANT_WAIT ##1
			state_reg != lp_pkg::ST_GRANT_WAIT;
	endproperty
	a_grant_delay: assert property (p_grant_delay) else $error("grant not 20 clocks after response");

	property p_ratio_first;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_RATIO_DOWN) |-> !vid_low_reg ##1 ratio_low_reg;
	endproperty
	a_ratio_first: assert property (p_ratio_first) else $error("vid moved before ratio");

	property p_vid_first;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_VID_UP) |-> ratio_low_reg && !vid_low_reg;
	endproperty
	a_vid_first: assert property (p_vid_first) else $error("ratio restored before vid");

	property p_grant_exit;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_GRANT && !stopclk && !ext_reg && !ret_halt_reg) |=>
			state_reg == lp_pkg::ST_NORMAL;
	endproperty
	a_grant_exit: assert property (p_grant_exit) else $error("stop-grant did not return to normal");

	property p_grant_snoop;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_GRANT && stopclk && snoop_req && !reset_fall) |=>
			state_reg == lp_pkg::ST_GRANT_SNOOP && snoop_serve;
	endproperty
	a_grant_snoop: assert property (p_grant_snoop) else $error("snoop in stop-grant not taken");

	property p_pending;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_GRANT && ev.smi) |=> pend_reg.smi;
	endproperty
	a_pending: assert property (p_pending) else $error("smi lost during stop-grant");

	property p_snoop_back;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_HALT_SNOOP && snoop_done && !reset_fall) |=>
			state_reg == lp_pkg::ST_HALT;
	endproperty
	a_snoop_back: assert property (p_snoop_back) else $error("no return to halt after snoop");

	property p_reset_grant;
		@(posedge clk) disable iff (!nrst)
		(state_reg == lp_pkg::ST_GRANT && stopclk && !snoop_req && reset_fall) |=>
			state_reg == lp_pkg::ST_GRANT && init_start;
	endproperty
	a_reset_grant: assert property (p_reset_grant) else $error("reset left stop-grant");
endmodule // low_power_state_controller

/* rtl/pin_sync.sv */
// Purpose: two-flop synchroniser for a bundle of pins
// Assumes: pins are asynchronous to clk
// Notes: first stage is read by the second stage only
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= RESET_VAL;
			q_reg <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule // pin_sync

/* rtl/vid_stepper.sv */
// Purpose: walks the voltage code one entry at a time towards a target
// Assumes: target may change at any cycle
// Notes: a step every VID_STEP_CLKS cycles, so the regulator can follow
`timescale 1ns/10ps
module vid_stepper (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [lp_pkg::VID_W-1:0] target,
	output logic [lp_pkg::VID_W-1:0] vid,
	output logic at_target
);
	logic [lp_pkg::VID_W-1:0] vid_reg;
	logic [lp_pkg::CNT_W-1:0] tick_reg;

	// ==========================================
	// step pacing
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_reg <= '0;
		end else if (vid_reg == target || tick_reg == lp_pkg::VID_STEP_CLKS - 1'b1) begin
			tick_reg <= '0;
		end else begin
			tick_reg <= tick_reg + 1'b1;
		end
	end

	// ==========================================
	// single-entry steps
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vid_reg <= lp_pkg::VID_RESET_CODE;
		end else if (vid_reg != target && tick_reg == lp_pkg::VID_STEP_CLKS - 1'b1) begin
			if (vid_reg < target) begin
				vid_reg <= vid_reg + 1'b1;
			end else begin
				vid_reg <= vid_reg - 1'b1;
			end
		end
	end

	assign vid = vid_reg;
	assign at_target = (vid_reg == target);
endmodule // vid_stepper

/* tb/chipset_model.sv */
// Purpose: system-side model answering grant acknowledge cycles and raising snoops
// Assumes: drives on the falling edge of clk, like the bench
// Notes: delay comes from the bench so answers can be prompt or slow
`timescale 1ns/10ps
module chipset_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic stop_grant_cycle_req,
	input wire logic snoop_serve,
	input wire logic snoop_go,
	input wire logic [3:0] delay,
	output logic bus_resp_done,
	output logic snoop_req,
	output logic snoop_done
);
	int cnt = 0;
	int scnt = 0;
	initial begin
		bus_resp_done = 1'h0;
		snoop_req = 1'h0;
		snoop_done = 1'h0;
	end
	// ==========================================
	// grant acknowledge: one response per request, after a chosen wait
	always @(negedge clk) begin
		bus_resp_done <= 1'h0;
		if (!nrst || stop_grant_cycle_req !== 1'h1) begin
			cnt = 0;
		end else if (cnt >= int'(delay)) begin
			bus_resp_done <= 1'h1;
			cnt = -100;
		end else begin
			cnt++;
		end
	end
	// ==========================================
	// snoops: held until served, completed by this side like another agent would
	// otherwise the bus stays quiet while the device sits in stop-grant
	always @(negedge clk) begin
		snoop_done <= 1'h0;
		if (!nrst) begin
			snoop_req <= 1'h0;
			scnt = 0;
		end else if (snoop_go && !snoop_req) begin
			snoop_req <= 1'h1;
		end else if (snoop_req && snoop_serve === 1'h1) begin
			scnt++;
			if (scnt > int'(delay)) begin
				snoop_done <= 1'h1;
				snoop_req <= 1'h0;
				scnt = 0;
			end
		end
	end
endmodule // chipset_model

/* tb/tb.sv */
// Purpose: self-checking bench of the low-power state controller
// Assumes: pins and controls change on the falling edge of clk
// Notes: operating points and response delays are random from a fixed seed
`timescale 1ns/10ps
module tb;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	lp_pkg::pins_type pins = 6'h3C;
	logic [1:0] core_halt_exec = 2'h0;
	logic smi_exit_valid = 1'h0;
	logic smi_exit_to_halt = 1'h0;
	logic snoop_go = 1'h0;
	logic ext_halt_en = 1'h0;
	logic ext_grant_en = 1'h0;
	logic [3:0] delay = 4'h0;
	logic [lp_pkg::RATIO_W-1:0] normal_ratio = 5'h08;
	logic [lp_pkg::RATIO_W-1:0] low_ratio = 5'h04;
	logic [lp_pkg::VID_W-1:0] normal_vid = 6'h10;
	logic [lp_pkg::VID_W-1:0] low_vid = 6'h04;
	logic snoop_req, snoop_done, bus_resp_done, stop_grant_cycle_req, snoop_serve, init_start;
	lp_pkg::lp_state_type lp_state;
	logic [1:0] core_run;
	lp_pkg::events_type event_service;
	logic [lp_pkg::RATIO_W-1:0] core_ratio;
	logic [lp_pkg::VID_W-1:0] voltage_id_code;
	int fails = 0;
	int cmp_count = 0;
	int n_ev[4] = '{0, 0, 0, 0};
	int b[4];
	int k;
	int n;
	always #12.5 clk = ~clk;
	low_power_state_controller i_dut (.clk(clk), .nrst(nrst), .pins(pins),
		.core_halt_exec(core_halt_exec), .smi_exit_valid(smi_exit_valid),
		.smi_exit_to_halt(smi_exit_to_halt), .snoop_req(snoop_req), .snoop_done(snoop_done),
		.bus_resp_done(bus_resp_done), .ext_halt_en(ext_halt_en), .ext_grant_en(ext_grant_en),
		.normal_ratio(normal_ratio), .low_ratio(low_ratio), .normal_vid(normal_vid),
		.low_vid(low_vid), .lp_state(lp_state), .core_run(core_run),
		.stop_grant_cycle_req(stop_grant_cycle_req), .snoop_serve(snoop_serve),
		.init_start(init_start), .event_service(event_service), .core_ratio(core_ratio),
		.voltage_id_code(voltage_id_code));
	chipset_model i_chipset (.clk(clk), .nrst(nrst), .stop_grant_cycle_req(stop_grant_cycle_req),
		.snoop_serve(snoop_serve), .snoop_go(snoop_go), .delay(delay),
		.bus_resp_done(bus_resp_done), .snoop_req(snoop_req), .snoop_done(snoop_done));
	// ==========================================
	// delivered events: smi, init, lint, init_start
	always @(posedge clk) begin
		n_ev[0] += int'(event_service.smi === 1'h1);
		n_ev[1] += int'(event_service.init === 1'h1);
		n_ev[2] += int'(event_service.lint === 1'h1);
		n_ev[3] += int'(init_start === 1'h1);
	end
	// ==========================================
	// tasks
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(negedge clk);
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_st(input lp_pkg::lp_state_type got, input lp_pkg::lp_state_type exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait; running out ends the run
	task automatic wait_st(input lp_pkg::lp_state_type s);
		for (int i = 0; i < 400 && lp_state !== s; i++) @(negedge clk);
		chk_st(lp_state, s);
		if (lp_state !== s) report_and_stop();
	endtask
	task automatic halt_all();
		core_halt_exec = 2'h3;
		tick(1);
		core_halt_exec = 2'h0;
	endtask
	// an edge on one event pin, held long enough to pass the synchroniser
	task automatic pulse(input int w);
		if (w == 0) pins.system_mgmt_interrupt_n = 1'h0;
		if (w == 1) pins.init_request_n = 1'h0;
		if (w == 2) pins.local_interrupt_pins = 2'h1;
		if (w == 3) pins.bus_reset_n = 1'h0;
		tick(4);
		// stop-clock keeps its level; only the pulsed pin goes back to idle
		pins = '{1'b1, pins.stop_clock_request_n, 1'b1, 1'b1, 2'h0};
		tick(4);
	endtask
	task automatic grant_cycle();
		delay = 4'($urandom_range(15));
		pins.stop_clock_request_n = 1'h0;
		wait_st(lp_pkg::ST_GRANT_ACK);
		chk_val(8'(stop_grant_cycle_req), 8'h01);
		wait_st(lp_pkg::ST_GRANT_WAIT);
		n = 0;
		while (lp_state === lp_pkg::ST_GRANT_WAIT && n < 40) begin
			n++;
			@(negedge clk);
		end
		chk_val(8'(n), 8'h14);
	endtask
	// ==========================================
	// main sequence
	initial begin
		n = $urandom(52101);
		normal_ratio = 5'h08 + 5'($urandom_range(7));
		low_ratio = 5'h04 + 5'($urandom_range(3));
		normal_vid = 6'h10 + 6'($urandom_range(15));
		low_vid = 6'h04 + 6'($urandom_range(7));
		tick(5);
		nrst = 1'h1;
		tick(2);
		chk_st(lp_state, lp_pkg::ST_NORMAL);
		chk_val(8'(core_ratio), 8'(normal_ratio));
		tick(80);
		core_halt_exec = 2'h1;
		tick(1);
		core_halt_exec = 2'h0;
		tick(3);
		chk_val(8'(core_run), 8'h02);
		chk_st(lp_state, lp_pkg::ST_NORMAL);
		core_halt_exec = 2'h2;
		tick(1);
		core_halt_exec = 2'h0;
		tick(3);
		chk_st(lp_state, lp_pkg::ST_HALT);
		for (k = 0; k < 3; k++) begin
			if (k > 0) halt_all();
			wait_st(lp_pkg::ST_HALT);
			b = n_ev;
			pulse(k);
			wait_st(lp_pkg::ST_NORMAL);
			tick(2);
			chk_val(8'(n_ev[k] - b[k]), 8'h01);
			chk_val(8'(core_run), 8'h03);
		end
		halt_all();
		wait_st(lp_pkg::ST_HALT);
		b = n_ev;
		pulse(3);
		chk_val(8'(n_ev[3] - b[3]), 8'h01);
		chk_st(lp_state, lp_pkg::ST_NORMAL);
		smi_exit_valid = 1'h1;
		smi_exit_to_halt = 1'h1;
		tick(1);
		smi_exit_valid = 1'h0;
		wait_st(lp_pkg::ST_HALT);
		// non-blocking, so the model reads it one falling edge later without a race
		snoop_go <= 1'h1;
		tick(1);
		snoop_go <= 1'h0;
		wait_st(lp_pkg::ST_HALT_SNOOP);
		chk_val(8'(snoop_serve), 8'h01);
		wait_st(lp_pkg::ST_HALT);
		grant_cycle();
		wait_st(lp_pkg::ST_GRANT);
		pins.stop_clock_request_n = 1'h1;
		wait_st(lp_pkg::ST_HALT);
		pulse(1);
		wait_st(lp_pkg::ST_NORMAL);
		smi_exit_valid = 1'h1;
		smi_exit_to_halt = 1'h0;
		tick(1);
		smi_exit_valid = 1'h0;
		tick(3);
		chk_st(lp_state, lp_pkg::ST_NORMAL);
		grant_cycle();
		wait_st(lp_pkg::ST_GRANT);
		b = n_ev;
		pulse(0);
		pulse(0);
		pulse(2);
		chk_val(8'(n_ev[0] + n_ev[2] - b[0] - b[2]), 8'h00);
		snoop_go <= 1'h1;
		tick(1);
		snoop_go <= 1'h0;
		wait_st(lp_pkg::ST_GRANT_SNOOP);
		chk_val(8'(snoop_serve), 8'h01);
		wait_st(lp_pkg::ST_GRANT);
		pins.stop_clock_request_n = 1'h0;
		pulse(3);
		pins.stop_clock_request_n = 1'h0;
		chk_st(lp_state, lp_pkg::ST_GRANT);
		chk_val(8'(n_ev[3] - b[3]), 8'h01);
		pins.stop_clock_request_n = 1'h1;
		wait_st(lp_pkg::ST_NORMAL);
		tick(3);
		chk_val(8'(n_ev[0] - b[0]), 8'h01);
		chk_val(8'(n_ev[2] - b[2]), 8'h01);
		ext_halt_en = 1'h1;
		halt_all();
		wait_st(lp_pkg::ST_RATIO_DOWN);
		tick(1);
		chk_val(8'(voltage_id_code), 8'(normal_vid));
		wait_st(lp_pkg::ST_VID_DOWN);
		chk_val(8'(core_ratio), 8'(low_ratio));
		wait_st(lp_pkg::ST_HALT);
		chk_val(8'(voltage_id_code), 8'(low_vid));
		pulse(2);
		wait_st(lp_pkg::ST_VID_UP);
		tick(1);
		chk_val(8'(core_ratio), 8'(low_ratio));
		wait_st(lp_pkg::ST_RATIO_UP);
		chk_val(8'(voltage_id_code), 8'(normal_vid));
		wait_st(lp_pkg::ST_NORMAL);
		tick(2);
		chk_val(8'(core_ratio), 8'(normal_ratio));
		ext_halt_en = 1'h0;
		ext_grant_en = 1'h1;
		grant_cycle();
		wait_st(lp_pkg::ST_GRANT);
		chk_val(8'(core_ratio), 8'(low_ratio));
		chk_val(8'(voltage_id_code), 8'(low_vid));
		pins.stop_clock_request_n = 1'h1;
		wait_st(lp_pkg::ST_NORMAL);
		tick(2);
		chk_val(8'(core_ratio), 8'(normal_ratio));
		chk_val(8'(voltage_id_code), 8'(normal_vid));
		report_and_stop();
	end
endmodule // tb
